// file: complementary_output_generator.sv
// complementary output waveform generator with apb registers
// ********************************
// ********************************
`timescale 1ns/100ps
`default_nettype none
module complementary_output_generator (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic [6:0] src_in,
    input wire logic fault_in,
    output logic drive_out_a,
    output logic drive_out_b,
    output logic drive_out_c,
    output logic drive_out_d
);

    // ********************************
    // state
    // ********************************
    typedef struct packed {
        logic [31:0] ctrl;
        logic [6:0] rise_en;
        logic [6:0] fall_en;
        logic [6:0] fall_mode;
        logic [31:0] timing;
        logic [31:0] rdata;
        waveform_pkg::drive_state_t st;
        logic prim;
        logic pair;
        logic pri_out;
        logic cmp_out;
        logic [5:0] dead_cnt;
        logic [5:0] blank_cnt;
        logic blank_fall;
    } gen_state_t;
    gen_state_t s_r, s_nxt;

    logic [6:0] lvl, rise_e, fall_e;
    logic rise_ev, fall_edge_ev, fall_level_ev, phr_done, phf_done, phr_busy, phf_busy;
    logic enabled, half, push, apb_wr, apb_rd;
    logic [2:0] md;

    // ********************************
    // helpers
    // ********************************
    function automatic logic [5:0] tfield(input logic [31:0] t, input int lsb);
        tfield = t[lsb +: waveform_pkg::time_width];
    endfunction : tfield

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] strb);
        for (int i = 0; i < 4; i++) begin
            merge[8*i +: 8] = strb[i] ? wd[8*i +: 8] : old[8*i +: 8];
        end
    endfunction : merge

    // sources: 0 pin, 1 cmp1, 2 cmp2, 3 logic cell, 4 cc1, 5 cc2, 6 pwm_unit_3
    event_sync u_sync (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .raw_in(src_in),
        .level_out(lvl),
        .rise_out(rise_e),
        .fall_out(fall_e)
    );

    assign md = s_r.ctrl[waveform_pkg::ctrl_md_lsb +: 3];
    assign half = (md == waveform_pkg::md_half_bridge);
    assign push = (md == waveform_pkg::md_push_pull);
    assign enabled = s_r.ctrl[waveform_pkg::ctrl_en_bit] & (half | push);

    // blanking masks rises while rising blank runs and falls while falling blank runs
    assign rise_ev = enabled & (|(rise_e & s_r.rise_en)) &
                     ~((s_r.blank_cnt != 6'h00) & ~s_r.blank_fall);
    assign fall_edge_ev = enabled & (|(fall_e & s_r.fall_en & s_r.fall_mode)) &
                          ~((s_r.blank_cnt != 6'h00) & s_r.blank_fall);
    assign fall_level_ev = enabled & (|(~lvl & s_r.fall_en & ~s_r.fall_mode)) &
                           ~((s_r.blank_cnt != 6'h00) & s_r.blank_fall);

    delay_timer u_phase_rise (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .start_in(rise_ev & ~phr_busy),
        .cancel_in(fault_in | ~enabled),
        .count_in(tfield(s_r.timing, waveform_pkg::phase_r_lsb)),
        .busy_out(phr_busy),
        .done_out(phr_done)
    );

    delay_timer u_phase_fall (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .start_in(fall_edge_ev & ~phf_busy),
        .cancel_in(fault_in | ~enabled | rise_ev),
        .count_in(tfield(s_r.timing, waveform_pkg::phase_f_lsb)),
        .busy_out(phf_busy),
        .done_out(phf_done)
    );

    assign apb_wr = psel_in & penable_in & pwrite_in;
    assign apb_rd = psel_in & ~penable_in & ~pwrite_in;

    // ********************************
    // next state
    // ********************************
    always_comb begin
        s_nxt = s_r;
        // register writes take effect at the access edge, zero wait states
        if (apb_wr) begin
            case (paddr_in)
                waveform_pkg::ctrl_addr: s_nxt.ctrl = merge(s_r.ctrl, pwdata_in, pstrb_in);
                waveform_pkg::rise_src_addr: if (pstrb_in[0]) s_nxt.rise_en = pwdata_in[6:0];
                waveform_pkg::fall_src_addr: if (pstrb_in[0]) s_nxt.fall_en = pwdata_in[6:0];
                waveform_pkg::fall_mode_addr: begin
                    if (pstrb_in[0]) s_nxt.fall_mode = pwdata_in[6:0];
                end
                waveform_pkg::timing_addr: s_nxt.timing = merge(s_r.timing, pwdata_in, pstrb_in);
                default: s_nxt.rdata = s_r.rdata;
            endcase
        end
        // read data captured in setup so it is a flop at the access edge
        if (apb_rd) begin
            case (paddr_in)
                waveform_pkg::ctrl_addr: s_nxt.rdata = s_r.ctrl;
                waveform_pkg::rise_src_addr: s_nxt.rdata = {25'h0000000, s_r.rise_en};
                waveform_pkg::fall_src_addr: s_nxt.rdata = {25'h0000000, s_r.fall_en};
                waveform_pkg::fall_mode_addr: s_nxt.rdata = {25'h0000000, s_r.fall_mode};
                waveform_pkg::timing_addr: s_nxt.rdata = s_r.timing;
                waveform_pkg::status_addr: begin
                    s_nxt.rdata = {26'h0000000, s_r.pair, s_r.cmp_out, s_r.pri_out,
                                   fault_in, s_r.st};
                end
                default: s_nxt.rdata = 32'h0000_0000;
            endcase
        end

        if (s_r.dead_cnt != 6'h00) s_nxt.dead_cnt = s_r.dead_cnt - 6'h01;
        if (s_r.blank_cnt != 6'h00) s_nxt.blank_cnt = s_r.blank_cnt - 6'h01;

        case (s_r.st)
            waveform_pkg::st_idle: begin
                if (rise_ev) s_nxt.st = waveform_pkg::st_rise_wait;
            end
            waveform_pkg::st_rise_wait: begin
                if (phr_done) begin
                    s_nxt.st = waveform_pkg::st_active;
                    s_nxt.prim = 1'b1;
                    s_nxt.pair = ~s_r.pair;
                    s_nxt.dead_cnt = tfield(s_r.timing, waveform_pkg::dead_lsb);
                    s_nxt.blank_cnt = tfield(s_r.timing, waveform_pkg::blank_f_lsb);
                    s_nxt.blank_fall = 1'b1;
                end
            end
            waveform_pkg::st_active: begin
                if (fall_level_ev | phf_done) begin
                    s_nxt.st = waveform_pkg::st_idle;
                    s_nxt.prim = 1'b0;
                    s_nxt.dead_cnt = tfield(s_r.timing, waveform_pkg::dead_lsb);
                    s_nxt.blank_cnt = tfield(s_r.timing, waveform_pkg::blank_r_lsb);
                    s_nxt.blank_fall = 1'b0;
                end else if (fall_edge_ev) begin
                    s_nxt.st = waveform_pkg::st_fall_wait;
                end
            end
            waveform_pkg::st_fall_wait: begin
                if (fall_level_ev | phf_done) begin
                    s_nxt.st = waveform_pkg::st_idle;
                    s_nxt.prim = 1'b0;
                    s_nxt.dead_cnt = tfield(s_r.timing, waveform_pkg::dead_lsb);
                    s_nxt.blank_cnt = tfield(s_r.timing, waveform_pkg::blank_r_lsb);
                    s_nxt.blank_fall = 1'b0;
                end
            end
            default: s_nxt.st = waveform_pkg::st_idle;
        endcase

        // fault or disable overrides everything, outputs go inactive at once
        if (fault_in | ~enabled) begin
            s_nxt.st = waveform_pkg::st_idle;
            s_nxt.prim = 1'b0;
            s_nxt.dead_cnt = 6'h00;
            s_nxt.blank_cnt = 6'h00;
        end

        // outputs: a side turns off at once, other side waits out the dead time
        if (half) begin
            s_nxt.pri_out = s_nxt.prim & (s_nxt.dead_cnt == 6'h00);
            s_nxt.cmp_out = ~s_nxt.prim & (s_nxt.dead_cnt == 6'h00) & enabled &
                            ~fault_in;
        end else begin
            s_nxt.pri_out = s_nxt.prim & s_nxt.pair & (s_nxt.dead_cnt == 6'h00);
            s_nxt.cmp_out = s_nxt.prim & ~s_nxt.pair & (s_nxt.dead_cnt == 6'h00);
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ********************************
    // outputs
    // ********************************
    assign pready_out = 1'b1;
    assign pslverr_out = 1'b0;
    assign prdata_out = s_r.rdata;
    // push-pull ignores steering so a mirrors c and b mirrors d
    assign drive_out_a = s_r.pri_out & (push | s_r.ctrl[waveform_pkg::ctrl_steer_lsb]);
    assign drive_out_c = s_r.pri_out & (push | s_r.ctrl[waveform_pkg::ctrl_steer_lsb + 2]);
    assign drive_out_b = s_r.cmp_out & (push | s_r.ctrl[waveform_pkg::ctrl_steer_lsb + 1]);
    assign drive_out_d = s_r.cmp_out & (push | s_r.ctrl[waveform_pkg::ctrl_steer_lsb + 3]);

    // ********************************
    // checks
    // ********************************
    a_no_overlap: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !(s_r.pri_out && s_r.cmp_out))
        else $error("primary and complement both active");
    a_fault_kills: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        fault_in |=> !s_r.pri_out && !s_r.cmp_out)
        else $error("drive active after fault");
    a_pp_mirror: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        push |-> (drive_out_a == drive_out_c) && (drive_out_b == drive_out_d))
        else $error("push-pull pairs differ");
    a_pair_flip: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (s_r.st == waveform_pkg::st_rise_wait && phr_done && enabled && !fault_in)
        |=> s_r.pair != $past(s_r.pair))
        else $error("pair did not alternate");
    a_mode_bit7: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        apb_rd && paddr_in == waveform_pkg::fall_mode_addr |=> prdata_out[31:7] == 25'h0)
        else $error("mode register upper bits not zero");
    a_level_fall: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        s_r.st == waveform_pkg::st_active && fall_level_ev |=> s_r.st == waveform_pkg::st_idle)
        else $error("level falling event not immediate");
    a_disabled_src: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (s_r.fall_en == 7'h00) |-> !fall_edge_ev && !fall_level_ev)
        else $error("disabled source caused falling event");
    a_phase_wait: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        s_r.st == waveform_pkg::st_idle && rise_ev |=> !s_r.prim)
        else $error("drive started before phase delay");
    a_mode_sel: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !(half || push) |=> s_r.st == waveform_pkg::st_idle)
        else $error("running in unsupported mode");
    c_half_cycle: cover property (@(posedge clk_in) half && s_r.pri_out ##[1:200] s_r.cmp_out);
    c_push_cycle: cover property (@(posedge clk_in) push && drive_out_a ##[1:200] drive_out_b);
    c_fault: cover property (@(posedge clk_in) s_r.pri_out && fault_in);
endmodule : complementary_output_generator
`default_nettype wire

// file: waveform_pkg.sv
// shared constants for the complementary output waveform generator
package waveform_pkg;

    // ********************************
    // register map (byte addresses)
    // ********************************
    localparam logic [11:0] ctrl_addr = 12'h000;
    localparam logic [11:0] rise_src_addr = 12'h004;
    localparam logic [11:0] fall_src_addr = 12'h008;
    localparam logic [11:0] fall_mode_addr = 12'h00c;
    localparam logic [11:0] timing_addr = 12'h010;
    localparam logic [11:0] status_addr = 12'h014;

    // ********************************
    // fields and reset values
    // ********************************
    localparam int ctrl_en_bit = 0;
    localparam int ctrl_md_lsb = 1;
    localparam int ctrl_steer_lsb = 4;
    localparam int ctrl_shut_bit = 8;
    localparam logic [2:0] md_half_bridge = 3'h4;
    localparam logic [2:0] md_push_pull = 3'h5;
    localparam int src_count = 7;
    localparam int fall_mode_width = 7;
    localparam logic [31:0] ctrl_reset = 32'h0000_0000;
    localparam logic [6:0] src_reset = 7'h00;
    localparam logic [6:0] fall_mode_reset = 7'h00;
    localparam logic [31:0] timing_reset = 32'h0000_0000;
    localparam int time_width = 6;
    localparam int dead_lsb = 0;
    localparam int blank_r_lsb = 6;
    localparam int blank_f_lsb = 12;
    localparam int phase_r_lsb = 18;
    localparam int phase_f_lsb = 24;

    typedef enum logic [1:0] {st_idle, st_rise_wait, st_active, st_fall_wait} drive_state_t;

endpackage : waveform_pkg

// file: event_sync.sv
// two-stage synchroniser with rise and fall edge detection per event source
`timescale 1ns/100ps
`default_nettype none
module event_sync (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic [6:0] raw_in,
    output logic [6:0] level_out,
    output logic [6:0] rise_out,
    output logic [6:0] fall_out
);
    typedef struct packed {
        logic [6:0] meta;
        logic [6:0] sync;
        logic [6:0] prev;
    } sync_state_t;
    sync_state_t s_r, s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.meta = raw_in;
        s_nxt.sync = s_r.meta;
        s_nxt.prev = s_r.sync;
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // meta feeds only the second stage, edges come from later stages
    assign level_out = s_r.sync;
    assign rise_out = s_r.sync & ~s_r.prev;
    assign fall_out = ~s_r.sync & s_r.prev;

    a_edge_once: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (rise_out != 7'h00) |=> ((rise_out & $past(rise_out)) == 7'h00))
        else $error("edge reported twice");
endmodule : event_sync
`default_nettype wire

// file: delay_timer.sv
// loadable down counter signalling its expiry with a one-cycle pulse
`timescale 1ns/100ps
`default_nettype none
module delay_timer (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic start_in,
    input wire logic cancel_in,
    input wire logic [5:0] count_in,
    output logic busy_out,
    output logic done_out
);
    typedef struct packed {
        logic busy;
        logic done;
        logic [5:0] cnt;
    } tmr_state_t;
    tmr_state_t s_r, s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        if (cancel_in) begin
            s_nxt.busy = 1'b0;
        end else if (start_in) begin
            if (count_in == 6'h00) begin
                s_nxt.done = 1'b1;
                s_nxt.busy = 1'b0;
            end else begin
                s_nxt.busy = 1'b1;
                s_nxt.cnt = count_in;
            end
        end else if (s_r.busy) begin
            if (s_r.cnt == 6'h01) begin
                s_nxt.busy = 1'b0;
                s_nxt.done = 1'b1;
            end
            s_nxt.cnt = s_r.cnt - 6'h01;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign busy_out = s_r.busy;
    assign done_out = s_r.done;
endmodule : delay_timer
`default_nettype wire

// file: power_stage.sv
// behavioural half-bridge power stage with a peak current sense comparator
`timescale 1ns/100ps
`default_nettype none
module power_stage #(
    parameter int on_cycles = 20
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic hi_side_in,
    output logic sense_out
);
    int cnt_r;

    // ************
    // current ramp
    // ************
    // comparator trips once the high side has conducted long enough, then stays
    // low until the switch opens, so each conduction gives a single falling edge
    always @(posedge clk_in) begin
        if (sys_rst_in || !hi_side_in) begin
            cnt_r <= 0;
        end else if (cnt_r < on_cycles) begin
            cnt_r <= cnt_r + 1;
        end
    end
    assign sense_out = hi_side_in && (cnt_r < on_cycles);
endmodule : power_stage
`default_nettype wire

// file: testbench.sv
// self-checking testbench of the complementary output generator
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module testbench;
    logic clk_in = 1'b0, sys_rst_in = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fault = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata_out;
    logic pready_out, pslverr_out, drive_out_a, drive_out_b, drive_out_c, drive_out_d, sense;
    logic [6:0] src_r = 7'h00;
    logic [1:0] smp = 2'h0;
    logic [31:0] gap_r = 32'h0000_0000;
    logic [31:0] exp_q[$];
    string nm_q[$];
    int error_cnt = 0, checks_done = 0, cyc = 0, dt, n;
    logic [31:0] rv;
    wire logic [3:0] drv = {drive_out_a, drive_out_b, drive_out_c, drive_out_d};

    always #10 clk_in = ~clk_in;

    complementary_output_generator uut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .pstrb_in(4'hf), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out),
        .src_in({src_r[6:2], sense, src_r[0]}), .fault_in(fault),
        .drive_out_a(drive_out_a), .drive_out_b(drive_out_b),
        .drive_out_c(drive_out_c), .drive_out_d(drive_out_d));
    power_stage #(.on_cycles(20)) stage (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .hi_side_in(drive_out_a), .sense_out(sense));

    // ************
    // result watcher
    // ************
    // notes are popped once into locals, the compare macro reads its arguments twice
    always @(posedge clk_in) begin : read_watch
        string nm;
        logic [31:0] ex;
        if (psel && penable && !pwrite && pready_out === 1'b1 && exp_q.size() > 0) begin
            nm = nm_q.pop_front();
            ex = exp_q.pop_front();
            `CHK(nm, ex, prdata_out)
            `CHK("slverr", 1'b0, pslverr_out)
        end
    end
    // drive levels are looked at mid-cycle, where the output flops have settled
    always @(negedge clk_in) begin : drive_watch
        string nm;
        logic [31:0] ex;
        if (smp != 2'h0 && exp_q.size() > 0) begin
            nm = nm_q.pop_front();
            ex = exp_q.pop_front();
            `CHK(nm, ex, (smp == 2'h1) ? {28'h0, drv} : gap_r)
        end
    end

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_in);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        do @(posedge clk_in); while (pready_out !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        nm_q.push_back("read");
        apb(1'b0, a, 32'h0000_0000);
    endtask : rd

    // waits a bounded time for the outputs to settle, then notes the check
    task automatic exp_drv(input logic [3:0] v, input int lim);
        int k;
        k = 0;
        while (k < lim && drv !== v) begin
            @(posedge clk_in);
            #1;
            k++;
        end
        exp_q.push_back({28'h0, v});
        nm_q.push_back("drive");
        smp <= 2'h1;
        @(posedge clk_in);
        smp <= 2'h0;
    endtask : exp_drv

    task automatic set_src4(input logic v);
        @(posedge clk_in);
        src_r[4] <= v;
    endtask : set_src4

    task automatic summarize;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : summarize

    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            summarize();
        end
    end

    initial begin
        rv = $urandom(32'h97509973);
        repeat (12) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        // ************
        // registers
        // ************
        rd(waveform_pkg::fall_mode_addr, 32'h0000_0000);
        rd(12'h020, 32'h0000_0000);
        apb(1'b1, waveform_pkg::fall_mode_addr, 32'hffff_ffff);
        rd(waveform_pkg::fall_mode_addr, 32'h0000_007f);
        rv = $urandom();
        apb(1'b1, waveform_pkg::fall_mode_addr, rv);
        rd(waveform_pkg::fall_mode_addr, rv & 32'h0000_007f);
        // ************
        // half-bridge with dead time
        // ************
        dt = 2 + ($urandom() % 4);
        apb(1'b1, waveform_pkg::timing_addr, dt);
        apb(1'b1, waveform_pkg::fall_mode_addr, 32'h0000_0000);
        apb(1'b1, waveform_pkg::rise_src_addr, 32'h0000_0010);
        apb(1'b1, waveform_pkg::fall_src_addr, 32'h0000_0010);
        apb(1'b1, waveform_pkg::ctrl_addr, 32'h0000_00f9);
        exp_drv(4'b0101, 30);
        set_src4(1'b1);
        exp_drv(4'b1010, 30);
        set_src4(1'b0);
        exp_drv(4'b0000, 30);
        n = 0;
        while (n < 40 && drive_out_b !== 1'b1) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        gap_r = (n >= dt - 1);
        exp_q.push_back(32'h0000_0001);
        nm_q.push_back("dead time");
        smp <= 2'h2;
        @(posedge clk_in);
        smp <= 2'h0;
        apb(1'b1, waveform_pkg::ctrl_addr, 32'h0000_0039);
        set_src4(1'b1);
        exp_drv(4'b1000, 30);
        set_src4(1'b0);
        exp_drv(4'b0100, 30);
        // ************
        // push-pull alternation and fault
        // ************
        apb(1'b1, waveform_pkg::ctrl_addr, 32'h0000_000b);
        exp_drv(4'b0000, 30);
        for (int p = 0; p < 3; p++) begin
            set_src4(1'b1);
            exp_drv(p[0] ? 4'b0101 : 4'b1010, 30);
            set_src4(1'b0);
            exp_drv(4'b0000, 30);
        end
        set_src4(1'b1);
        exp_drv(4'b0101, 30);
        @(posedge clk_in);
        fault <= 1'b1;
        exp_drv(4'b0000, 4);
        set_src4(1'b0);
        @(posedge clk_in);
        fault <= 1'b0;
        // ************
        // event driven: edge-mode current sense ends the drive
        // ************
        apb(1'b1, waveform_pkg::timing_addr, 32'h0320_0000 | dt);
        apb(1'b1, waveform_pkg::fall_src_addr, 32'h0000_0002);
        apb(1'b1, waveform_pkg::fall_mode_addr, 32'h0000_0002);
        apb(1'b1, waveform_pkg::ctrl_addr, 32'h0000_00f9);
        exp_drv(4'b0101, 30);
        set_src4(1'b1);
        set_src4(1'b0);
        // rising phase delay of 8 still holds the complement here
        repeat (6) @(posedge clk_in);
        #1;
        exp_drv(4'b0101, 0);
        exp_drv(4'b1010, 30);
        repeat (8) @(posedge clk_in);
        #1;
        exp_drv(4'b1010, 0);
        exp_drv(4'b0101, 60);
        summarize();
    end
endmodule : testbench
`default_nettype wire
